// ### sifd_pkg.sv
// constants, field layout and types for the vector instruction field decoder
// Notes on behaviour
// [RL1] non-branch vector instructions use major opcode 30
// [RL2] vector branches: ten rs values under opcode 17
// [RL3] imm8 format: 8-bit immediate, format bits 25..24
// [RL4] imm5 format: immediate, format 22..21, op 25..23
// [RL5] bit index format: format/index 22..16, op 25..23
// [RL6] imm10 format: immediate, format 22..21, op 25..23
// [RL7] three-reg format: op 25..23, format 22..21
// [RL8] element format: format/index 21..16, op 25..22
// [RL9] three-reg float: op 25..22, selector bit 21
// [RL10] implicit-type format: op 25..21, format implied
// [RL11] memory imm10: format 1..0, op bit25+minor 5..2
// [RL12] two-reg format: op 25..18, format 17..16
// [RL13] two-reg float: op 25..17, selector bit 16
// [RL14] branch: 16-bit immediate, op 25..23, format 22..21
// [RL15] format is two-bit code, one-bit variant exists
// [RL16] element instructions pack format and index together
// [RL17] bad index or format raises reserved exception
// [RL18] byte index above 15 raises reserved exception
// [RL19] selected element broadcast to every destination lane
// [RL20] load/store offset counted in element-size units
// [RL21] widening ops: sources half width, same signedness
// [RL22] reserved minor opcode raises disabled or reserved
// [RL23] vector register assumed 128 bits wide
// [RL24] source 15..11, destination 10..6, minor 5..0
// [RL25] class, fields and exception produced together
package sifd_pkg;
    localparam int INSTR_W = 32;          // instruction word width
    localparam int VREG_BITS = 128;       // vector register width
    localparam int OPC_LSB = 26;          // major opcode position
    localparam int OPC_W = 6;
    localparam logic [5:0] OPC_VECTOR = 6'h1E; // vector major opcode (30)
    localparam logic [5:0] OPC_COPROCESSOR_ONE_OPCODE = 6'h11;   // coprocessor_one_opcode (17)
    localparam int MINOR_LSB = 0;         // minor opcode field
    localparam int MINOR_W = 6;
    localparam int REG_W = 5;             // vector register number width
    localparam int WD_LSB = 6;
    localparam int WS_LSB = 11;
    localparam int WT_LSB = 16;
    localparam int RS_LSB = 21;           // rs field of branches
    localparam int OP_W3_LSB = 23;        // operation fields by width
    localparam int OP_W4_LSB = 22;
    localparam int OP_W5_LSB = 21;
    localparam int OP_W8_LSB = 18;
    localparam int OP_W9_LSB = 17;
    localparam int OP_MI_BIT = 25;        // memory op high bit
    localparam int OP_MI_LSB = 2;         // memory op minor part
    localparam int OP_MI_W = 4;
    localparam int DF_MID_LSB = 21;       // two-bit format positions
    localparam int DF_I8_LSB = 24;
    localparam int DF_2R_LSB = 16;
    localparam int DF_MI_LSB = 0;
    localparam int DF1_3RF_BIT = 21;      // one-bit format selectors
    localparam int DF1_2RF_BIT = 16;
    localparam int IMM_LSB = 16;          // imm8/imm5/offset start
    localparam int I10_LSB = 11;
    localparam int DFN_LSB = 16;          // packed format/index fields
    localparam int DFN_W = 6;
    localparam int DFM_W = 7;
    localparam int OFS_W = 10;            // signed_offset_field width
    localparam int BYTE_OFS_W = 13;       // offset scaled to bytes
    // element format codes
    localparam logic [1:0] DF_BYTE = 2'h0;
    localparam logic [1:0] DF_HALF = 2'h1;
    localparam logic [1:0] DF_WORD = 2'h2;
    localparam logic [1:0] DF_DOUBLE = 2'h3;
    localparam logic [3:0] BYTE_BITS = 4'h8; // narrowest element
    // minor opcode allocation, 40 values in all
    localparam logic [5:0] MN_I8_LO = 6'h00, MN_I8_HI = 6'h02;
    localparam logic [5:0] MN_I5_LO = 6'h03, MN_I5_HI = 6'h07;
    localparam logic [5:0] MN_I10 = 6'h08;
    localparam logic [5:0] MN_BIT_LO = 6'h09, MN_BIT_HI = 6'h0A;
    localparam logic [5:0] MN_3R_LO = 6'h0B, MN_3R_HI = 6'h15;
    localparam logic [5:0] MN_ELM = 6'h19;
    localparam logic [5:0] MN_3RF_LO = 6'h1A, MN_3RF_HI = 6'h1D;
    localparam logic [5:0] MN_VEC = 6'h1E;
    localparam logic [5:0] MN_MI_LO = 6'h20, MN_MI_HI = 6'h2B;
    // implicit-type group sub-decode on bits 25..21
    localparam logic [4:0] VEC_OP_MAX = 5'h07;
    localparam logic [4:0] VEC_OP_2R = 5'h18;
    localparam logic [4:0] VEC_OP_2RF = 5'h19;
    // branch rs values: two implicit, eight with explicit format
    localparam logic [4:0] BR_RS_IMPL_A = 5'h0B;
    localparam logic [4:0] BR_RS_IMPL_B = 5'h0F;
    localparam logic [1:0] BR_RS_DF_TAG = 2'h3; // rs[4:3] marks df branches
    // format classes
    typedef enum logic [3:0] {
        fmt_none,
        imm8_format,
        imm5_format,
        bit_index_format,
        imm10_format,
        three_reg_format,
        element_index_format,
        three_reg_float_format,
        implicit_type_format,
        mem_imm10_format,
        two_reg_format,
        two_reg_float_format,
        branch_format
    } sifd_format_t;
endpackage

// ### sifd_decoder.sv
// registered field decoder for vector-extension instruction words
`timescale 1ns/100ps
`default_nettype none
module sifd_decoder (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic unit_enable,
    output logic dec_valid_q,
    output logic is_vector_q,
    output logic is_branch_q,
    output sifd_pkg::sifd_format_t format_q,
    output logic [5:0] minor_q,
    output logic [8:0] operation_q,
    output logic [1:0] element_format_q,
    output logic format_explicit_q,
    output logic one_bit_format_q,
    output logic format_sel_q,
    output logic [15:0] imm_q,
    output logic [12:0] byte_offset_q,
    output logic [4:0] elem_index_q,
    output logic [5:0] bit_index_q,
    output logic broadcast_q,
    output logic [4:0] elem_count_q,
    output logic [1:0] half_format_q,
    output logic half_format_valid_q,
    output logic [4:0] dest_vector_reg_q,
    output logic [4:0] source_vector_reg_q,
    output logic [4:0] target_vector_reg_q,
    output logic reserved_exc_q,
    output logic disabled_exc_q
);

    // element width in bits for a two-bit format code
    function automatic logic [7:0] elem_bits(input logic [1:0] df);
        elem_bits = 8'(sifd_pkg::BYTE_BITS) << df;
    endfunction

    // lanes in one vector register for a format code
    function automatic logic [4:0] elem_count(input logic [1:0] df);
        elem_count = 5'(sifd_pkg::VREG_BITS / int'(elem_bits(df))); // [RL23]
    endfunction

    // minor opcode to format class; fmt_none means reserved
    function automatic sifd_pkg::sifd_format_t minor_class(input logic [5:0] mn);
        if (mn >= sifd_pkg::MN_I8_LO && mn <= sifd_pkg::MN_I8_HI)
            minor_class = sifd_pkg::imm8_format;
        else if (mn >= sifd_pkg::MN_I5_LO && mn <= sifd_pkg::MN_I5_HI)
            minor_class = sifd_pkg::imm5_format;
        else if (mn == sifd_pkg::MN_I10)
            minor_class = sifd_pkg::imm10_format;
        else if (mn >= sifd_pkg::MN_BIT_LO && mn <= sifd_pkg::MN_BIT_HI)
            minor_class = sifd_pkg::bit_index_format;
        else if (mn >= sifd_pkg::MN_3R_LO && mn <= sifd_pkg::MN_3R_HI)
            minor_class = sifd_pkg::three_reg_format;
        else if (mn == sifd_pkg::MN_ELM)
            minor_class = sifd_pkg::element_index_format;
        else if (mn >= sifd_pkg::MN_3RF_LO && mn <= sifd_pkg::MN_3RF_HI)
            minor_class = sifd_pkg::three_reg_float_format;
        else if (mn == sifd_pkg::MN_VEC)
            minor_class = sifd_pkg::implicit_type_format;
        else if (mn >= sifd_pkg::MN_MI_LO && mn <= sifd_pkg::MN_MI_HI)
            minor_class = sifd_pkg::mem_imm10_format;
        else
            minor_class = sifd_pkg::fmt_none; // [RL22]
    endfunction

    // combinational decode results
    logic [5:0] opc;                  // major opcode
    logic [5:0] minor;                // minor opcode
    logic [4:0] rs;                   // branch rs field
    logic [5:0] dfn;                  // format_and_element_index
    logic [6:0] dfm;                  // format_and_bit_index
    logic [9:0] s10;                  // signed_offset_field
    logic vec_hit;                    // major opcode 30
    logic br_hit;                     // one of the ten branch rs values
    logic br_df;                      // branch with explicit format
    sifd_pkg::sifd_format_t fmt_d;
    logic [8:0] op_d;
    logic [1:0] df_d;
    logic df_explicit_d;
    logic one_bit_d;
    logic sel_d;
    logic [15:0] imm_d;
    logic [12:0] byte_ofs_d;
    logic [4:0] eidx_d;
    logic [5:0] bidx_d;
    logic bcast_d;
    logic bad_field_d;                // invalid packed format/index
    logic widen_src_d;                // format allows a half-width source

    assign opc = instr_word[sifd_pkg::OPC_LSB +: sifd_pkg::OPC_W];
    assign minor = instr_word[sifd_pkg::MINOR_LSB +: sifd_pkg::MINOR_W]; // [RL24]
    assign rs = instr_word[sifd_pkg::RS_LSB +: sifd_pkg::REG_W];
    assign dfn = instr_word[sifd_pkg::DFN_LSB +: sifd_pkg::DFN_W];
    assign dfm = instr_word[sifd_pkg::DFN_LSB +: sifd_pkg::DFM_W];
    assign s10 = instr_word[sifd_pkg::IMM_LSB +: sifd_pkg::OFS_W];
    assign vec_hit = (opc == sifd_pkg::OPC_VECTOR); // [RL1]
    // branches live under the coprocessor opcode, never under opcode 30
    assign br_df = (rs[4:3] == sifd_pkg::BR_RS_DF_TAG);
    assign br_hit = (opc == sifd_pkg::OPC_COPROCESSOR_ONE_OPCODE) &&
                    (rs == sifd_pkg::BR_RS_IMPL_A || rs == sifd_pkg::BR_RS_IMPL_B ||
                     br_df); // [RL2]

    // format class and per-format field extraction
    always_comb
    begin
        fmt_d = sifd_pkg::fmt_none;
        op_d = '0;
        df_d = sifd_pkg::DF_BYTE;
        df_explicit_d = 1'b0;
        one_bit_d = 1'b0;
        sel_d = 1'b0;
        imm_d = '0;
        byte_ofs_d = '0;
        eidx_d = '0;
        bidx_d = '0;
        bcast_d = 1'b0;
        bad_field_d = 1'b0;
        widen_src_d = 1'b0;
        if (br_hit)
        begin
            fmt_d = sifd_pkg::branch_format;
            op_d = 9'(instr_word[sifd_pkg::OP_W3_LSB +: 3]); // [RL14]
            imm_d = instr_word[15:0]; // [RL14]
            df_explicit_d = br_df;
            df_d = br_df ? instr_word[sifd_pkg::DF_MID_LSB +: 2] : sifd_pkg::DF_BYTE;
        end
        else if (vec_hit)
        begin
            fmt_d = minor_class(minor);
            case (fmt_d)
                sifd_pkg::imm8_format:
                begin
                    // format always comes from bits 25..24, never implied by the op
                    imm_d = 16'(instr_word[sifd_pkg::IMM_LSB +: 8]); // [RL3]
                    df_d = instr_word[sifd_pkg::DF_I8_LSB +: 2]; // [RL3]
                    df_explicit_d = 1'b1;
                end
                sifd_pkg::imm5_format:
                begin
                    imm_d = 16'(instr_word[sifd_pkg::IMM_LSB +: 5]); // [RL4]
                    df_d = instr_word[sifd_pkg::DF_MID_LSB +: 2]; // [RL4]
                    op_d = 9'(instr_word[sifd_pkg::OP_W3_LSB +: 3]); // [RL4]
                    df_explicit_d = 1'b1;
                end
                sifd_pkg::imm10_format:
                begin
                    imm_d = 16'(instr_word[sifd_pkg::I10_LSB +: 10]); // [RL6]
                    df_d = instr_word[sifd_pkg::DF_MID_LSB +: 2]; // [RL6]
                    op_d = 9'(instr_word[sifd_pkg::OP_W3_LSB +: 3]); // [RL6]
                    df_explicit_d = 1'b1;
                end
                sifd_pkg::bit_index_format:
                begin
                    // prefix 0 double, 10 word, 110 half, 1110 byte
                    op_d = 9'(instr_word[sifd_pkg::OP_W3_LSB +: 3]); // [RL5]
                    df_explicit_d = 1'b1;
                    if (!dfm[6])
                    begin
                        df_d = sifd_pkg::DF_DOUBLE;
                        bidx_d = dfm[5:0];
                    end
                    else if (!dfm[5])
                    begin
                        df_d = sifd_pkg::DF_WORD;
                        bidx_d = 6'(dfm[4:0]);
                    end
                    else if (!dfm[4])
                    begin
                        df_d = sifd_pkg::DF_HALF;
                        bidx_d = 6'(dfm[3:0]);
                    end
                    else if (!dfm[3])
                    begin
                        df_d = sifd_pkg::DF_BYTE;
                        bidx_d = 6'(dfm[2:0]);
                    end
                    else
                        bad_field_d = 1'b1; // [RL17]
                end
                sifd_pkg::three_reg_format:
                begin
                    op_d = 9'(instr_word[sifd_pkg::OP_W3_LSB +: 3]); // [RL7]
                    df_d = instr_word[sifd_pkg::DF_MID_LSB +: 2]; // [RL7]
                    df_explicit_d = 1'b1;
                    widen_src_d = 1'b1; // [RL21]
                end
                sifd_pkg::element_index_format:
                begin
                    // prefix 0 byte, 10 half, 110 word, 1110 double
                    op_d = 9'(instr_word[sifd_pkg::OP_W4_LSB +: 4]); // [RL8]
                    df_explicit_d = 1'b1;
                    bcast_d = 1'b1; // [RL19]
                    if (!dfn[5])
                    begin
                        df_d = sifd_pkg::DF_BYTE;
                        eidx_d = dfn[4:0]; // [RL16]
                    end
                    else if (!dfn[4])
                    begin
                        df_d = sifd_pkg::DF_HALF;
                        eidx_d = 5'(dfn[3:0]);
                    end
                    else if (!dfn[3])
                    begin
                        df_d = sifd_pkg::DF_WORD;
                        eidx_d = 5'(dfn[2:0]);
                    end
                    else if (!dfn[2])
                    begin
                        df_d = sifd_pkg::DF_DOUBLE;
                        eidx_d = 5'(dfn[1:0]);
                    end
                    else
                    begin
                        // vector and spare codes name no lane
                        df_explicit_d = 1'b0;
                        bcast_d = 1'b0;
                        bad_field_d = (dfn[1:0] != 2'h2); // [RL17]
                    end
                    // index must lie within the lane count of the format
                    if (df_explicit_d && eidx_d >= elem_count(df_d))
                        bad_field_d = 1'b1; // [RL18]
                end
                sifd_pkg::three_reg_float_format:
                begin
                    op_d = 9'(instr_word[sifd_pkg::OP_W4_LSB +: 4]); // [RL9]
                    one_bit_d = 1'b1; // [RL15]
                    sel_d = instr_word[sifd_pkg::DF1_3RF_BIT]; // [RL9]
                end
                sifd_pkg::implicit_type_format:
                begin
                    op_d = 9'(instr_word[sifd_pkg::OP_W5_LSB +: 5]); // [RL10]
                    if (op_d[4:0] == sifd_pkg::VEC_OP_2R)
                    begin
                        fmt_d = sifd_pkg::two_reg_format;
                        op_d = 9'(instr_word[sifd_pkg::OP_W8_LSB +: 8]); // [RL12]
                        df_d = instr_word[sifd_pkg::DF_2R_LSB +: 2]; // [RL12]
                        df_explicit_d = 1'b1;
                    end
                    else if (op_d[4:0] == sifd_pkg::VEC_OP_2RF)
                    begin
                        fmt_d = sifd_pkg::two_reg_float_format;
                        op_d = instr_word[sifd_pkg::OP_W9_LSB +: 9]; // [RL13]
                        one_bit_d = 1'b1;
                        sel_d = instr_word[sifd_pkg::DF1_2RF_BIT]; // [RL13]
                    end
                    else if (op_d[4:0] > sifd_pkg::VEC_OP_MAX)
                        fmt_d = sifd_pkg::fmt_none; // [RL22]
                end
                sifd_pkg::mem_imm10_format:
                begin
                    // op joins bit 25 with minor bits 5..2
                    op_d = 9'({instr_word[sifd_pkg::OP_MI_BIT],
                               minor[sifd_pkg::OP_MI_LSB +: sifd_pkg::OP_MI_W]}); // [RL11]
                    df_d = instr_word[sifd_pkg::DF_MI_LSB +: 2]; // [RL11]
                    df_explicit_d = 1'b1;
                    imm_d = 16'(s10);
                    // offset counts elements; scale to bytes with sign kept
                    byte_ofs_d = 13'(signed'(s10)) << df_d; // [RL20]
                end
                default: fmt_d = sifd_pkg::fmt_none; // reserved minor: nothing to extract
            endcase
        end
    end

    // handshake: results appear one edge after the word is offered
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            dec_valid_q <= 1'b0;
        else
            dec_valid_q <= instr_valid; // [RL25]
    end

    // class and opcode recognition, all captured on the same edge
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            is_vector_q <= 1'b0;
            is_branch_q <= 1'b0;
            format_q <= sifd_pkg::fmt_none;
            minor_q <= '0;
            dest_vector_reg_q <= '0;
            source_vector_reg_q <= '0;
            target_vector_reg_q <= '0;
        end
        else if (instr_valid)
        begin
            is_vector_q <= vec_hit; // [RL1]
            is_branch_q <= br_hit; // [RL2]
            format_q <= fmt_d; // [RL25]
            minor_q <= minor;
            // register numbers keep their fixed positions in every format
            dest_vector_reg_q <= instr_word[sifd_pkg::WD_LSB +: sifd_pkg::REG_W]; // [RL24]
            source_vector_reg_q <= instr_word[sifd_pkg::WS_LSB +: sifd_pkg::REG_W]; // [RL24]
            target_vector_reg_q <= instr_word[sifd_pkg::WT_LSB +: sifd_pkg::REG_W];
        end
    end

    // operation, format and immediates
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            operation_q <= '0;
            element_format_q <= sifd_pkg::DF_BYTE;
            format_explicit_q <= 1'b0;
            one_bit_format_q <= 1'b0;
            format_sel_q <= 1'b0;
            imm_q <= '0;
            byte_offset_q <= '0;
        end
        else if (instr_valid)
        begin
            operation_q <= op_d;
            element_format_q <= df_d; // [RL15]
            format_explicit_q <= df_explicit_d;
            one_bit_format_q <= one_bit_d; // [RL15]
            format_sel_q <= sel_d;
            imm_q <= imm_d;
            byte_offset_q <= byte_ofs_d; // [RL20]
        end
    end

    // lane selection, counts and widening source format
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            elem_index_q <= '0;
            bit_index_q <= '0;
            broadcast_q <= 1'b0;
            elem_count_q <= '0;
            half_format_q <= sifd_pkg::DF_BYTE;
            half_format_valid_q <= 1'b0;
        end
        else if (instr_valid)
        begin
            elem_index_q <= eidx_d; // [RL16]
            bit_index_q <= bidx_d; // [RL5]
            // one chosen lane feeds every destination lane
            broadcast_q <= bcast_d && !bad_field_d; // [RL19]
            elem_count_q <= df_explicit_d ? elem_count(df_d) : 5'h00; // [RL23]
            // destination names the wide format; sources are half width
            half_format_q <= df_d - 2'h1; // [RL21]
            half_format_valid_q <= widen_src_d && (df_d != sifd_pkg::DF_BYTE); // [RL21]
        end
    end

    // exceptions: a disabled unit wins so software can enable lazily
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reserved_exc_q <= 1'b0;
            disabled_exc_q <= 1'b0;
        end
        else
        begin
            // exceptions stand only for the word that caused them
            disabled_exc_q <= instr_valid && (vec_hit || br_hit) && !unit_enable; // [RL22]
            reserved_exc_q <= instr_valid && unit_enable && vec_hit &&
                              (fmt_d == sifd_pkg::fmt_none || bad_field_d); // [RL17]
        end
    end

endmodule
`default_nettype wire

// ### sifd_assertions.sv
// port-level concurrent checks for the vector instruction field decoder
`timescale 1ns/100ps
`default_nettype none
module sifd_checker (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic unit_enable,
    input wire logic dec_valid_q,
    input wire logic is_vector_q,
    input wire logic is_branch_q,
    input wire sifd_pkg::sifd_format_t format_q,
    input wire logic [5:0] minor_q,
    input wire logic [4:0] dest_vector_reg_q,
    input wire logic [4:0] source_vector_reg_q,
    input wire logic reserved_exc_q,
    input wire logic disabled_exc_q
);
    // word offered under the vector major opcode
    wire logic vec_in = instr_valid && instr_word[31:26] == sifd_pkg::OPC_VECTOR;
    // unallocated minor codes, 24 of the 64
    wire logic res_minor = instr_word[5:0] inside {[6'h16:6'h18], 6'h1F, [6'h2C:6'h3F]};
    // the ten branch encodings of the rs field
    wire logic br_rs = instr_word[25:21] inside {5'h0B, 5'h0F, [5'h18:5'h1F]};
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    valid_latency_a: assert property (instr_valid |=> dec_valid_q)
        else $error("no decode one cycle after a word");
    idle_quiet_a: assert property (!instr_valid |=>
        !(dec_valid_q || reserved_exc_q || disabled_exc_q)) else $error("decode without a word");
    vector_flag_a: assert property (instr_valid |=> is_vector_q == $past(vec_in))
        else $error("vector flag wrong");
    reg_fields_a: assert property (vec_in |=>
        {source_vector_reg_q, dest_vector_reg_q, minor_q} == $past(instr_word[15:0]))
        else $error("register or minor field wrong");
    unit_off_a: assert property (vec_in && !unit_enable |=>
        disabled_exc_q && !reserved_exc_q) else $error("disabled unit not reported");
    reserved_minor_a: assert property (vec_in && unit_enable && res_minor |=>
        reserved_exc_q && format_q == sifd_pkg::fmt_none) else $error("reserved minor missed");
    byte_index_a: assert property (vec_in && unit_enable && instr_word[5:0] == 6'h19 &&
        instr_word[21:20] == 2'b01 |=> reserved_exc_q) else $error("byte index above 15 accepted");
    branch_rs_a: assert property (instr_valid && instr_word[31:26] == sifd_pkg::OPC_COPROCESSOR_ONE_OPCODE |=>
        is_branch_q == $past(br_rs)) else $error("branch recognition wrong");
    fields_hold_a: assert property (!instr_valid |=> $stable(format_q) && $stable(minor_q))
        else $error("fields moved without a word");
    cover property (vec_in && !unit_enable);
    cover property (dec_valid_q && reserved_exc_q);
    cover property (is_branch_q && dec_valid_q);
endmodule
bind sifd_decoder sifd_checker u_chk (.*);
`default_nettype wire

// ### sifd_fetch_model.sv
// fetch and issue side model offering one instruction word at a time
`timescale 1ns/100ps
`default_nettype none
module sifd_fetch_model (
    input wire logic sys_clk,
    output logic instr_valid,
    output logic [31:0] instr_word,
    output logic unit_enable
);
    initial
    begin
        instr_valid = 1'b0;
        instr_word = 32'h0;
        unit_enable = 1'b1;
    end
    // offers w after gap+1 cycles; its inverse follows so stale data never matches
    task automatic issue(input logic [31:0] w, input logic en, input int gap);
        repeat (gap + 1) @(negedge sys_clk);
        instr_valid = 1'b1;
        instr_word = w;
        unit_enable = en;
        @(negedge sys_clk);
        instr_valid = 1'b0;
        instr_word = ~w;
        unit_enable = ~en;
    endtask
endmodule
`default_nettype wire

// ### sifd_tb.sv
// self-checking testbench for the vector instruction field decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    wire logic instr_valid, unit_enable;
    wire logic [31:0] instr_word;
    logic dec_valid_q, is_vector_q, is_branch_q, format_sel_q, broadcast_q, half_format_valid_q;
    logic reserved_exc_q, disabled_exc_q;
    sifd_pkg::sifd_format_t format_q;
    logic [8:0] operation_q;
    logic [1:0] element_format_q, half_format_q;
    logic [15:0] imm_q;
    logic [12:0] byte_offset_q;
    logic [4:0] elem_index_q, target_vector_reg_q;
    logic [5:0] bit_index_q;
    int n_errors = 0;
    int samples_checked = 0;
    always #5 sys_clk = ~sys_clk;
    sifd_fetch_model fetch (.sys_clk, .instr_valid, .instr_word, .unit_enable);
    sifd_decoder uut (.sys_clk, .nrst, .instr_valid, .instr_word, .unit_enable, .dec_valid_q,
        .is_vector_q, .is_branch_q, .format_q, .minor_q(), .operation_q, .element_format_q,
        .format_explicit_q(), .one_bit_format_q(), .format_sel_q, .imm_q, .byte_offset_q,
        .elem_index_q, .bit_index_q, .broadcast_q, .elem_count_q(), .half_format_q,
        .half_format_valid_q, .dest_vector_reg_q(), .source_vector_reg_q(),
        .target_vector_reg_q, .reserved_exc_q, .disabled_exc_q);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_fmt(input sifd_pkg::sifd_format_t got, input sifd_pkg::sifd_format_t exp);
        chk(16'(got), 16'(exp));
    endtask
    // one word; op 9'h1FF and df 3'h4 mean not checked
    task automatic run(input logic [31:0] w, input sifd_pkg::sifd_format_t f,
        input logic [8:0] op, input logic [2:0] df, input logic [1:0] exc);
        fetch.issue(w, 1'b1, 0);
        chk_fmt(format_q, f);
        if (op != 9'h1FF)
            chk(16'(operation_q), 16'(op));
        if (df != 3'h4)
            chk(16'(element_format_q), 16'(df));
        chk({14'h0, reserved_exc_q, disabled_exc_q}, 16'(exc));
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(negedge sys_clk);
        nrst = 1'b1;
        chk_fmt(format_q, sifd_pkg::fmt_none);
        run(32'h7BA50000, sifd_pkg::imm8_format, 9'h1FF, 3'h3, 2'h0);
        chk(imm_q, 16'h00A5);
        run(32'h7AD310C3, sifd_pkg::imm5_format, 9'h005, 3'h2, 2'h0);
        chk(imm_q, 16'h0013);
        run(32'h78F50009, sifd_pkg::bit_index_format, 9'h001, 3'h4, 2'h0);
        chk(16'(bit_index_q), 16'h0005);
        run(32'h79355808, sifd_pkg::imm10_format, 9'h002, 3'h1, 2'h0);
        chk(imm_q, 16'h02AB);
        run(32'h7924088B, sifd_pkg::three_reg_format, 9'h002, 3'h1, 2'h0);
        chk({half_format_valid_q, half_format_q, target_vector_reg_q}, 16'h0084);
        run(32'h78CF0019, sifd_pkg::element_index_format, 9'h003, 3'h0, 2'h0);
        chk({broadcast_q, elem_index_q}, 16'h002F);
        run(32'h7960001A, sifd_pkg::three_reg_float_format, 9'h005, 3'h4, 2'h0);
        chk(16'(format_sel_q), 16'h0001);
        run(32'h7860001E, sifd_pkg::implicit_type_format, 9'h003, 3'h4, 2'h0);
        run(32'h7BFF0022, sifd_pkg::mem_imm10_format, 9'h018, 3'h2, 2'h0);
        chk(16'(byte_offset_q), 16'h1FFC);
        run(32'h7B16001E, sifd_pkg::two_reg_format, 9'h0C5, 3'h2, 2'h0);
        run(32'h7B2D001E, sifd_pkg::two_reg_float_format, 9'h196, 3'h4, 2'h0);
        chk(16'(format_sel_q), 16'h0001);
        $display("format field tests done");
        fetch.issue(32'h78D00019, 1'b1, 2);
        chk(16'(reserved_exc_q), 16'h0001);
        run(32'h78000016, sifd_pkg::fmt_none, 9'h1FF, 3'h4, 2'h2);
        run(32'h7800003F, sifd_pkg::fmt_none, 9'h1FF, 3'h4, 2'h2);
        fetch.issue(32'h7924088B, 1'b0, 1);
        chk({14'h0, reserved_exc_q, disabled_exc_q}, 16'h0001);
        $display("exception tests done");
        run(32'h47201234, sifd_pkg::branch_format, 9'h006, 3'h1, 2'h0);
        chk(imm_q, 16'h1234);
        run(32'h45601234, sifd_pkg::branch_format, 9'h002, 3'h4, 2'h0);
        chk(16'(is_branch_q), 16'h0001);
        run(32'h44000000, sifd_pkg::fmt_none, 9'h1FF, 3'h4, 2'h0);
        chk({15'h0, is_branch_q}, 16'h0000);
        run(32'h00000000, sifd_pkg::fmt_none, 9'h1FF, 3'h4, 2'h0);
        chk({15'h0, is_vector_q}, 16'h0000);
        $display("opcode tests done");
        print_verdict();
    end
    initial
    begin
        #5000;
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
